// >>> design/dagsc_core.sv
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dagsc_core #(
    parameter int DATA_W = 16
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [dagsc_pkg::APB_AW-1:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire dagsc_pkg::dagsc_req_t REQ,
    output dagsc_pkg::dagsc_rsp_t RSP,
    output logic STACK_TRAP
);
    import dagsc_pkg::*;

    // Refuse any data width other than the one the logic serves
    if (DATA_W != 16) begin : g_width_check
        $error("dagsc_core supports only 16-bit data");
    end

    // Sign extend a literal of given width
    function automatic logic [15:0] sext(input logic [15:0] v, input int w);
        logic [15:0] m;
        m = 16'hFFFF << w;
        sext = v[w-1] ? (v | m) : (v & ~m);
    endfunction

    // Zero extend a literal of given width
    function automatic logic [15:0] zext(input logic [15:0] v, input int w);
        zext = v & ~(16'hFFFF << w);
    endfunction

    logic [15:0] limit_reg; // Stack limit, no reset value
    logic [15:0] sp_reg; // Stack pointer copy
    logic [15:0] sp_next;
    logic trap_en_reg; // Trap enable control
    logic ovf_seen_reg; // Sticky overflow seen
    logic unf_seen_reg; // Sticky underflow seen
    logic [15:0] ea; // Effective address
    logic [15:0] ptr_upd; // Updated pointer value
    logic ptr_wr; // Pointer writeback
    logic mem_acc; // Data memory access
    logic mem_wr; // Memory write
    logic [15:0] wdata; // Memory write data
    logic [15:0] lit_val; // Extended literal
    logic uses_sp; // Stack pointer used
    logic ovf_hit; // Overflow condition
    logic unf_hit; // Underflow condition
    logic [15:0] src_ptr; // Pointer source value
    logic apb_wr; // APB write strobe
    logic apb_rd; // APB read strobe

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && PENABLE && !PWRITE;

    // Pointer source: own copy of stack pointer, else from decoder
    assign src_ptr = (REQ.ptr_idx == SP_IDX) ? sp_reg : REQ.ptr_val;

    // Literal widths by class
    always_comb begin
        unique case (REQ.lit_kind)
            DAGSC_LIT5: lit_val = zext(REQ.literal, LIT5_W);
            DAGSC_LIT10: lit_val = zext(REQ.literal, LIT10_W);
            DAGSC_LIT8: lit_val = zext(REQ.literal, LIT8_W);
            DAGSC_LIT16: lit_val = REQ.literal;
            DAGSC_LIT_BRANCH: lit_val = sext(REQ.literal, BRANCH_W);
            DAGSC_LIT_INTDIS: lit_val = zext(REQ.literal, INTDIS_W);
            default: lit_val = REQ.literal;
        endcase
    end

    // Effective address per mode
    always_comb begin
        ea = 16'h0000;
        ptr_upd = src_ptr;
        ptr_wr = 1'b0;
        mem_acc = 1'b1;
        mem_wr = REQ.mem_dest;
        wdata = 16'h0000;
        unique case (REQ.mode)
            DAGSC_FILE_DIRECT: begin
                ea = {3'h0, REQ.file_addr};
                mem_wr = !REQ.to_work_reg;
            end
            DAGSC_REG_DIRECT: begin
                mem_acc = 1'b0;
                mem_wr = 1'b0;
            end
            DAGSC_INDIRECT: ea = src_ptr;
            DAGSC_POST_INC: begin
                ea = src_ptr;
                ptr_upd = src_ptr + WORD_STEP;
                ptr_wr = 1'b1;
            end
            DAGSC_POST_DEC: begin
                ea = src_ptr;
                ptr_upd = src_ptr - WORD_STEP;
                ptr_wr = 1'b1;
            end
            DAGSC_PRE_INC: begin
                ptr_upd = src_ptr + WORD_STEP;
                ea = ptr_upd;
                ptr_wr = 1'b1;
            end
            DAGSC_PRE_DEC: begin
                ptr_upd = src_ptr - WORD_STEP;
                ea = ptr_upd;
                ptr_wr = 1'b1;
            end
            DAGSC_INDEXED: ea = src_ptr + REQ.offs_val;
            DAGSC_LIT_OFFSET: ea = src_ptr + lit_val;
            DAGSC_LITERAL: begin
                mem_acc = 1'b0;
                mem_wr = 1'b0;
            end
            DAGSC_PUSH, DAGSC_CALL_PUSH, DAGSC_EXC_PUSH: begin
                ea = sp_reg;
                ptr_upd = sp_reg + WORD_STEP;
                ptr_wr = 1'b1;
                mem_wr = 1'b1;
                if (REQ.mode == DAGSC_CALL_PUSH) begin
                    wdata = {1'b0, REQ.pc_word[14:0]};
                end else if (REQ.mode == DAGSC_EXC_PUSH) begin
                    wdata = {REQ.status_low_byte, REQ.pc_word[7:0]};
                end else begin
                    wdata = REQ.literal;
                end
            end
            DAGSC_POP: begin
                ptr_upd = sp_reg - WORD_STEP;
                ea = ptr_upd;
                ptr_wr = 1'b1;
                mem_wr = 1'b0;
            end
            default: mem_acc = 1'b0;
        endcase
    end

    // Stack checks on any stack-pointer based address
    assign uses_sp = REQ.valid && ptr_wr_or_sp(REQ.mode, REQ.ptr_idx);
    function automatic logic ptr_wr_or_sp(input dagsc_mode_t m,
                                          input logic [REG_IDX_W-1:0] i);
        ptr_wr_or_sp = (m == DAGSC_PUSH) || (m == DAGSC_POP) ||
            (m == DAGSC_CALL_PUSH) || (m == DAGSC_EXC_PUSH) ||
            ((i == SP_IDX) && (m != DAGSC_FILE_DIRECT) &&
             (m != DAGSC_REG_DIRECT) && (m != DAGSC_LITERAL));
    endfunction
    assign ovf_hit = uses_sp && (ea > limit_reg);
    assign unf_hit = uses_sp && (ea < SFR_BOUND);

    // Stack pointer tracking
    always_comb begin
        sp_next = sp_reg;
        if (apb_wr && PADDR == STACK_PTR_OFS && PSTRB[0] && PSTRB[1]) begin
            sp_next = {PWDATA[15:1], 1'b0};
        end
        if (REQ.valid && ptr_wr && REQ.ptr_idx == SP_IDX) begin
            sp_next = {ptr_upd[15:1], 1'b0};
        end
        if (REQ.valid && (REQ.mode == DAGSC_PUSH || REQ.mode == DAGSC_POP ||
            REQ.mode == DAGSC_CALL_PUSH || REQ.mode == DAGSC_EXC_PUSH)) begin
            sp_next = {ptr_upd[15:1], 1'b0};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sp_reg <= SP_RESET;
        end else begin
            sp_reg <= sp_next;
        end
    end

    // Stack limit, deliberately not reset
    always_ff @(posedge SYS_CLK) begin
        if (apb_wr && PADDR == STACK_LIMIT_OFS) begin
            if (PSTRB[0]) begin
                limit_reg[7:0] <= {PWDATA[7:1], 1'b0};
            end
            if (PSTRB[1]) begin
                limit_reg[15:8] <= PWDATA[15:8];
            end
        end
    end

    // Trap control and sticky status; set wins over clear
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            trap_en_reg <= 1'b1;
            ovf_seen_reg <= 1'b0;
            unf_seen_reg <= 1'b0;
        end else begin
            if (apb_wr && PADDR == TRAP_CTRL_OFS && PSTRB[0]) begin
                trap_en_reg <= PWDATA[0];
            end
            if (apb_wr && PADDR == TRAP_STAT_OFS && PSTRB[0]) begin
                if (PWDATA[0]) ovf_seen_reg <= 1'b0;
                if (PWDATA[1]) unf_seen_reg <= 1'b0;
            end
            if (ovf_hit) ovf_seen_reg <= 1'b1;
            if (unf_hit) unf_seen_reg <= 1'b1;
        end
    end

    // Result and trap outputs, registered with the access
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RSP <= '0;
            STACK_TRAP <= 1'b0;
        end else begin
            RSP.valid <= REQ.valid;
            RSP.eff_addr <= ea;
            RSP.mem_access <= REQ.valid && mem_acc;
            RSP.mem_write <= REQ.valid && mem_acc && mem_wr;
            RSP.wdata <= wdata;
            RSP.ptr_wb <= REQ.valid && ptr_wr;
            RSP.ptr_idx <= REQ.ptr_idx;
            RSP.ptr_new <= ptr_upd;
            RSP.dest_idx <= (REQ.mode == DAGSC_FILE_DIRECT) ? ZERO_REG_IDX
                                                            : REQ.ptr_idx;
            RSP.lit_val <= lit_val;
            STACK_TRAP <= trap_en_reg && (ovf_hit || unf_hit);
        end
    end

    // APB slave: zero wait state, error on unmapped address
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE) begin
                unique case (PADDR)
                    STACK_LIMIT_OFS: PRDATA <= {16'h0000, limit_reg[15:1],
                                                1'b0};
                    STACK_PTR_OFS: PRDATA <= {16'h0000, sp_reg};
                    TRAP_STAT_OFS: PRDATA <= {30'h0, unf_seen_reg,
                                              ovf_seen_reg};
                    TRAP_CTRL_OFS: PRDATA <= {31'h0, trap_en_reg};
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // Assertions: one clock domain, so a default clock and disable
    // Every property below is sampled on the core clock edge
    default clocking core_cb @(posedge SYS_CLK);
    endclocking
    // Properties stay quiet while reset is held
    default disable iff (SYS_RST);

    // Push on the stack steps the pointer up by one word
    push_step_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PUSH && !apb_wr) |=>
        (sp_reg == $past(sp_reg) + WORD_STEP))
        else $error("push did not step pointer");

    // Pop reads the word just below the pointer
    pop_addr_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_POP) |=>
        (RSP.eff_addr == $past(sp_reg) - WORD_STEP))
        else $error("pop address not predecremented");

    // Push writes at the free word that the pointer marks
    push_addr_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PUSH) |=>
        (RSP.eff_addr == $past(sp_reg) && RSP.mem_write))
        else $error("push address not at free word");

    // Return address from a call never carries a set top bit
    call_msb_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_CALL_PUSH) |=> !RSP.wdata[15])
        else $error("call push top bit set");

    // Exception frame carries the status byte in its upper half
    exc_frame_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_EXC_PUSH) |=>
        (RSP.wdata[15:8] == $past(REQ.status_low_byte)))
        else $error("exception frame lacks status byte");

    // Any write of the low lane leaves the limit word aligned
    limit_lsb_a: assert property (
        (apb_wr && PADDR == STACK_LIMIT_OFS && PSTRB[0]) |=>
        !limit_reg[0])
        else $error("limit bit zero set");

    // Pushing while the pointer sits on the limit is still legal
    at_limit_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PUSH && sp_reg == limit_reg &&
         sp_reg >= SFR_BOUND) |=> !STACK_TRAP)
        else $error("trap at limit push");

    // Push beyond the limit raises the trap when enabled
    over_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PUSH && sp_reg > limit_reg &&
         trap_en_reg) |=> STACK_TRAP)
        else $error("overflow missed");

    // Stack access below the register area raises the trap
    under_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PUSH && sp_reg < SFR_BOUND &&
         trap_en_reg) |=> STACK_TRAP)
        else $error("underflow missed");

    // A trap is always the echo of a request one cycle earlier
    trap_pulse_a: assert property (
        STACK_TRAP |-> $past(REQ.valid))
        else $error("trap without access");

    // Plain indirect uses the pointer itself as the address
    indirect_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_INDIRECT && REQ.ptr_idx != SP_IDX)
        |=> (RSP.eff_addr == $past(REQ.ptr_val)))
        else $error("indirect address wrong");

    // Post-increment addresses first, then steps the pointer
    post_mod_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_POST_INC && REQ.ptr_idx != SP_IDX)
        |=> (RSP.eff_addr == $past(REQ.ptr_val) &&
             RSP.ptr_new == $past(REQ.ptr_val) + WORD_STEP))
        else $error("post increment wrong");

    // Pre-decrement steps the pointer, then addresses with it
    pre_mod_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_PRE_DEC && REQ.ptr_idx != SP_IDX)
        |=> (RSP.eff_addr == $past(REQ.ptr_val) - WORD_STEP &&
             RSP.ptr_new == RSP.eff_addr))
        else $error("pre decrement wrong");

    // Indexed form adds the offset register to the pointer
    indexed_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_INDEXED && REQ.ptr_idx != SP_IDX)
        |=> (RSP.eff_addr == $past(REQ.ptr_val) + $past(REQ.offs_val)))
        else $error("indexed address wrong");

    // File register addresses never leave near space
    file_a: assert property (
        (REQ.valid && REQ.mode == DAGSC_FILE_DIRECT) |=>
        (RSP.eff_addr < NEAR_LIMIT))
        else $error("file address outside near space");

    // Register bus answers in the first access cycle
    apb_ready_a: assert property (
        (PSEL && !PENABLE) |=> PREADY)
        else $error("apb not ready");

    // Main scenarios: push, pop, exception push, file access, trap
    push_cv: cover property (REQ.valid && REQ.mode == DAGSC_PUSH);
    pop_cv: cover property (REQ.valid && REQ.mode == DAGSC_POP);
    exc_cv: cover property (REQ.valid && REQ.mode == DAGSC_EXC_PUSH);
    file_cv: cover property (REQ.valid && REQ.mode == DAGSC_FILE_DIRECT);
    trap_cv: cover property (STACK_TRAP);
endmodule // dagsc_core

// >>> design/dagsc_pkg.sv
package dagsc_pkg;
    // Register bus layout
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] STACK_LIMIT_OFS = 12'h000;
    localparam logic [APB_AW-1:0] STACK_PTR_OFS = 12'h004;
    localparam logic [APB_AW-1:0] TRAP_STAT_OFS = 12'h008;
    localparam logic [APB_AW-1:0] TRAP_CTRL_OFS = 12'h00C;
    // Reset values and boundaries
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam logic [15:0] SFR_BOUND = 16'h0800;
    localparam logic [15:0] NEAR_LIMIT = 16'h2000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    // Field widths of instruction literals
    localparam int FILE_AW = 13;
    localparam int LIT5_W = 5;
    localparam int LIT10_W = 10;
    localparam int LIT8_W = 8;
    localparam int LIT16_W = 16;
    localparam int BRANCH_W = 16;
    localparam int INTDIS_W = 14;
    localparam int REG_IDX_W = 4;
    localparam logic [REG_IDX_W-1:0] SP_IDX = 4'hF;
    localparam logic [REG_IDX_W-1:0] ZERO_REG_IDX = 4'h0;

    // Addressing modes
    typedef enum logic [3:0] {
        DAGSC_FILE_DIRECT,
        DAGSC_REG_DIRECT,
        DAGSC_INDIRECT,
        DAGSC_POST_INC,
        DAGSC_POST_DEC,
        DAGSC_PRE_INC,
        DAGSC_PRE_DEC,
        DAGSC_INDEXED,
        DAGSC_LIT_OFFSET,
        DAGSC_LITERAL,
        DAGSC_PUSH,
        DAGSC_POP,
        DAGSC_CALL_PUSH,
        DAGSC_EXC_PUSH
    } dagsc_mode_t;

    // Literal classes
    typedef enum logic [2:0] {
        DAGSC_LIT5,
        DAGSC_LIT10,
        DAGSC_LIT8,
        DAGSC_LIT16,
        DAGSC_LIT_BRANCH,
        DAGSC_LIT_INTDIS
    } dagsc_lit_t;

    // Address request from the decoder
    typedef struct packed {
        logic valid;
        dagsc_mode_t mode;
        logic [REG_IDX_W-1:0] ptr_idx;
        logic [15:0] ptr_val;
        logic [15:0] offs_val;
        logic [15:0] literal;
        dagsc_lit_t lit_kind;
        logic [FILE_AW-1:0] file_addr;
        logic to_work_reg;
        logic mem_dest;
        logic [15:0] pc_word;
        logic [7:0] status_low_byte;
    } dagsc_req_t;

    // Address result towards data memory
    typedef struct packed {
        logic valid;
        logic [15:0] eff_addr;
        logic mem_access;
        logic mem_write;
        logic [15:0] wdata;
        logic ptr_wb;
        logic [REG_IDX_W-1:0] ptr_idx;
        logic [15:0] ptr_new;
        logic [REG_IDX_W-1:0] dest_idx;
        logic [15:0] lit_val;
    } dagsc_rsp_t;
endpackage

// >>> test/dagsc_mem_model.sv
`timescale 1ns/1ps
// Data memory at the far side: keeps every word the block writes
module dagsc_mem_model (
    input wire logic clk,
    input wire dagsc_pkg::dagsc_rsp_t rsp
);
    import dagsc_pkg::*;
    // Word store indexed by the aligned address
    logic [15:0] mem [0:32767];
    // Writes land at the edge after the result is presented
    always_ff @(posedge clk) begin
        if (rsp.valid && rsp.mem_write) begin
            mem[rsp.eff_addr[15:1]] <= rsp.wdata;
        end
    end
endmodule // dagsc_mem_model

// >>> test/data_address_gen_stack_check_tb.sv
`timescale 1ns/1ps
// Bench for the address generator and stack checker
module data_address_gen_stack_check_tb;
    import dagsc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [APB_AW-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dagsc_req_t req_i = '0;
    dagsc_req_t q;
    dagsc_rsp_t rsp;
    logic stack_trap;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int num_checks = 0;
    // Mode table for the pointer forms, pointer 0x1000
    dagsc_mode_t md [7] = '{DAGSC_INDIRECT, DAGSC_POST_INC,
        DAGSC_POST_DEC, DAGSC_PRE_INC, DAGSC_PRE_DEC, DAGSC_INDEXED,
        DAGSC_LIT_OFFSET};
    logic [15:0] ea_x [7] = '{16'h1000, 16'h1000, 16'h1000, 16'h1002,
        16'h0FFE, 16'h1030, 16'h1006};
    logic [15:0] pn_x [7] = '{16'h1000, 16'h1002, 16'h0FFE, 16'h1002,
        16'h0FFE, 16'h1000, 16'h1000};
    // Literal classes and their expected widths for an all-ones literal
    dagsc_lit_t lk [6] = '{DAGSC_LIT5, DAGSC_LIT10, DAGSC_LIT8,
        DAGSC_LIT16, DAGSC_LIT_BRANCH, DAGSC_LIT_INTDIS};
    logic [15:0] lv_x [6] = '{16'h001F, 16'h03FF, 16'h00FF, 16'hFFFF,
        16'hFFFF, 16'h3FFF};

    // Clock of 5 ns period
    always #2.5 sys_clk = ~sys_clk;

    dagsc_core u_dagsc_core (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .REQ(req_i), .RSP(rsp),
        .STACK_TRAP(stack_trap));
    dagsc_mem_model u_dagsc_mem_model (.clk(sys_clk), .rsp(rsp));

    // Closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    // Send request q, check address and trap in the answer cycle
    task automatic send(input logic [15:0] ea, input logic trap);
        q.valid = 1'b1;
        @(posedge sys_clk);
        req_i <= q;
        @(posedge sys_clk);
        req_i <= '0;
        #1;
        chk("rsp_valid", 32'h1, {31'h0, rsp.valid});
        chk("eff_addr", {16'h0, ea}, {16'h0, rsp.eff_addr});
        chk("trap", {31'h0, trap}, {31'h0, stack_trap});
    endtask

    // Push or pop on the stack pointer
    task automatic stk(input dagsc_mode_t m, input logic [15:0] ea,
                       input logic trap);
        q = '0;
        q.mode = m;
        q.ptr_idx = SP_IDX;
        q.pc_word = 16'hFFFF;
        q.status_low_byte = 8'hA5;
        send(ea, trap);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, STACK_PTR_OFS, '0);
        chk("sp_reset", 32'h0800, rd);
        apb(1'b0, TRAP_CTRL_OFS, '0);
        chk("ctrl_reset", 32'h1, rd);
        apb(1'b0, TRAP_STAT_OFS, '0);
        chk("stat_reset", 32'h0, rd);
        apb(1'b0, 12'h010, '0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b1, STACK_LIMIT_OFS, 32'h0805);
        apb(1'b0, STACK_LIMIT_OFS, '0);
        chk("limit_bit0", 32'h0804, rd);
        stk(DAGSC_CALL_PUSH, 16'h0800, 1'b0);
        chk("call_data", 32'h7FFF, {16'h0, rsp.wdata});
        chk("sp_inc", 32'h0802, {16'h0, rsp.ptr_new});
        stk(DAGSC_EXC_PUSH, 16'h0802, 1'b0);
        chk("exc_data", 32'hA5FF, {16'h0, rsp.wdata});
        chk("mem_word", 32'h7FFF,
            {16'h0, u_dagsc_mem_model.mem[16'h0400]});
        stk(DAGSC_PUSH, 16'h0804, 1'b0);
        stk(DAGSC_PUSH, 16'h0806, 1'b1);
        @(posedge sys_clk);
        #1;
        chk("trap_pulse", 32'h0, {31'h0, stack_trap});
        apb(1'b0, TRAP_STAT_OFS, '0);
        chk("ovf_flag", 32'h1, rd & 32'h3);
        apb(1'b1, TRAP_STAT_OFS, 32'h3);
        apb(1'b1, STACK_PTR_OFS, 32'h0802);
        stk(DAGSC_POP, 16'h0800, 1'b0);
        stk(DAGSC_POP, 16'h07FE, 1'b1);
        stk(DAGSC_PUSH, 16'h07FE, 1'b1);
        apb(1'b0, TRAP_STAT_OFS, '0);
        chk("unf_flag", 32'h2, rd & 32'h3);
        // Pointer modes through working pointer three
        for (int k = 0; k < 7; k++) begin
            q = '0;
            q.mode = md[k];
            q.ptr_idx = 4'h3;
            q.ptr_val = 16'h1000;
            q.offs_val = 16'h0030;
            q.literal = 16'h0006;
            q.lit_kind = DAGSC_LIT10;
            q.mem_dest = 1'b1;
            send(ea_x[k], 1'b0);
            chk("ptr_idx", 32'h3, {28'h0, rsp.ptr_idx});
            chk("mem_write", 32'h1, {31'h0, rsp.mem_write});
            chk("ptr_wb", {31'h0, (k > 0 && k < 5)},
                {31'h0, rsp.ptr_wb});
            if (k > 0 && k < 5) begin
                chk("ptr_new", {16'h0, pn_x[k]},
                    {16'h0, rsp.ptr_new});
            end
        end
        // Literal widths per class
        for (int k = 0; k < 6; k++) begin
            q = '0;
            q.mode = DAGSC_LITERAL;
            q.literal = 16'hFFFF;
            q.lit_kind = lk[k];
            send(16'h0000, 1'b0);
            chk("lit_mem_acc", 32'h0, {31'h0, rsp.mem_access});
            chk("lit_val", {16'h0, lv_x[k]},
                {16'h0, rsp.lit_val});
        end
        // Register direct base operand, no data memory access
        q = '0;
        q.mode = DAGSC_REG_DIRECT;
        q.ptr_idx = 4'h2;
        q.mem_dest = 1'b1;
        send(16'h0000, 1'b0);
        chk("reg_mem_acc", 32'h0, {31'h0, rsp.mem_access});
        chk("reg_dest", 32'h2, {28'h0, rsp.dest_idx});
        // File register direct, result to memory then to register zero
        for (int k = 0; k < 2; k++) begin
            q = '0;
            q.mode = DAGSC_FILE_DIRECT;
            q.file_addr = 13'h1FFF;
            q.to_work_reg = k[0];
            send(16'h1FFF, 1'b0);
            chk("dest_idx", 32'h0, {28'h0, rsp.dest_idx});
            chk("mem_write", {31'h0, ~k[0]},
                {31'h0, rsp.mem_write});
        end
        give_verdict();
    end
endmodule // data_address_gen_stack_check_tb
